// *** hw/operand_addr_pkg.sv ***
// shared types and constants for the operand address generator
package operand_addr_pkg;

  localparam int ADDR_W   = 32;
  localparam int REG_CNT  = 8;
  localparam int REG_SEL_W = 3;

  // general register index of the stack pointer register
  localparam logic [2:0] STACK_POINTER_SEL = 3'h4;

  // mode encodings: two operand modes, nine memory modes
  localparam int MODE_W = 4;
  typedef enum logic [3:0] {
    MODE_REGISTER      = 4'h0,
    MODE_IMMEDIATE     = 4'h1,
    MODE_DIRECT        = 4'h2,
    MODE_REG_INDIRECT  = 4'h3,
    MODE_BASED         = 4'h4,
    MODE_INDEX         = 4'h5,
    MODE_SCALED_INDEX  = 4'h6,
    MODE_BASED_INDEX   = 4'h7,
    MODE_BASED_SCALED  = 4'h8,
    MODE_BASED_INDEX_D = 4'h9,
    MODE_BASED_SCALED_D = 4'ha
  } addr_mode_e;

  // displacement sizes
  typedef enum logic [1:0] {
    DISP_NONE = 2'h0,
    DISP_8    = 2'h1,
    DISP_16   = 2'h2,
    DISP_32   = 2'h3
  } disp_size_e;

  // operand access widths
  typedef enum logic [1:0] {
    WIDTH_8  = 2'h0,
    WIDTH_16 = 2'h1,
    WIDTH_32 = 2'h2
  } op_width_e;

  // reset values
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  // which elements a mode uses
  typedef struct packed {
    logic use_base;
    logic use_index;
    logic use_scale;
    logic use_disp;
    logic is_memory;
  } mode_use_s;

  // request from the decoder
  typedef struct packed {
    addr_mode_e  mode;
    logic [2:0]  base_sel;
    logic [2:0]  index_sel;
    logic [1:0]  scale_shift;
    disp_size_e  disp_size;
    logic [31:0] disp;
    logic [31:0] immediate;
    logic [2:0]  reg_sel;
    op_width_e   reg_width;
    logic        reg_high_byte;
    logic [31:0] seg_base;
  } addr_req_s;

  // result toward segment and paging translation
  typedef struct packed {
    logic        is_memory;
    logic [31:0] offset;
    logic [31:0] linear;
    logic [31:0] operand;
    logic        addr32;
    logic        op32;
  } addr_res_s;

endpackage

// *** hw/disp_extend.sv ***
// sign extension of the instruction displacement
`timescale 1ns/1ps
module disp_extend
(
  input  wire operand_addr_pkg::disp_size_e size,
  input  wire logic [31:0]                  raw,
  output logic [31:0]                       value
);

  // ==========================================================
  // extension
  always_comb
  begin
    unique case (size)
      operand_addr_pkg::DISP_NONE: value = 32'h0;          // [RULE10]
      operand_addr_pkg::DISP_8:    value = {{24{raw[7]}}, raw[7:0]};   // [RULE5]
      operand_addr_pkg::DISP_16:   value = {{16{raw[15]}}, raw[15:0]}; // [RULE11]
      operand_addr_pkg::DISP_32:   value = raw;            // [RULE5]
    endcase
  end

endmodule

// *** hw/reg_operand_select.sv ***
// general register read at 8, 16 or 32 bit width
`timescale 1ns/1ps
module reg_operand_select
(
  input  wire logic [31:0]                 reg_value,
  input  wire operand_addr_pkg::op_width_e width,
  input  wire logic                        high_byte,
  output logic [31:0]                      value
);

  // ==========================================================
  // width select
  always_comb
  begin
    unique case (width)
      operand_addr_pkg::WIDTH_8:                                      // [RULE2]
        value = high_byte ? {24'h0, reg_value[15:8]} : {24'h0, reg_value[7:0]};
      operand_addr_pkg::WIDTH_16: value = {16'h0, reg_value[15:0]};   // [RULE2]
      default:                    value = reg_value;                  // [RULE2]
    endcase
  end

endmodule

// *** hw/operand_address_generator.sv ***
// operand selection and effective / linear address datapath
`timescale 1ns/1ps
// How it works
// RULE1: eleven modes: register, immediate, and nine memory address forms.
// RULE2: register mode reads a general register at 8, 16 or 32 bits.
// RULE3: immediate mode takes the value from the instruction field.
// RULE4: linear address is segment base plus effective offset.
// RULE5: displacement is an 8, 16 or 32 bit instruction immediate.
// RULE6: any general register may be the base.
// RULE7: stack pointer register refused as index; request flagged invalid.
// RULE8: index scaled by 1, 2, 4 or 8 via a 0..3 bit shift.
// RULE9: one cycle latency; base plus index adds one extra clock.
// RULE10: offset is base plus scaled index plus displacement, absent parts zero.
// RULE11: direct mode offset is displacement alone, 8, 16 or 32 bits.
// RULE12: register indirect offset is base register only.
// RULE13: based mode offset is base plus displacement.
// RULE14: index mode offset is unscaled index plus displacement.
// RULE15: scaled index mode offset is scaled index plus displacement.
// RULE16: based index offset is base plus unscaled index.
// RULE17: based scaled index offset is base plus scaled index.
// RULE18: based index with displacement sums all three, unscaled.
// RULE19: based scaled index with displacement sums all three, scaled.
// RULE20: code segment default size bit picks 16 or 32 bit lengths.
// RULE21: sums are 32 bits; carry out of bit 31 dropped.
module operand_address_generator
#(
  parameter int REG_CNT = operand_addr_pkg::REG_CNT
)
(
  input  wire logic                        clk,
  input  wire logic                        srst,
  input  wire logic                        req_valid,
  input  wire operand_addr_pkg::addr_req_s req,
  input  wire logic                        default_size32,
  input  wire logic                        op_size_override,
  input  wire logic                        addr_size_override,
  input  wire logic [REG_CNT*32-1:0]       reg_file,
  output logic                             req_ready,
  output logic                             res_valid,
  output operand_addr_pkg::addr_res_s      res,
  output logic                             index_fault
);

  // ==========================================================
  // helpers
  function automatic operand_addr_pkg::mode_use_s mode_use
  (
    input operand_addr_pkg::addr_mode_e m
  );
    operand_addr_pkg::mode_use_s u;
    u = '0;
    unique case (m)
      operand_addr_pkg::MODE_REGISTER:     u = '0;
      operand_addr_pkg::MODE_IMMEDIATE:    u = '0;
      operand_addr_pkg::MODE_DIRECT:       u = 5'b00011;      // [RULE11]
      operand_addr_pkg::MODE_REG_INDIRECT: u = 5'b10001;      // [RULE12]
      operand_addr_pkg::MODE_BASED:        u = 5'b10011;      // [RULE13]
      operand_addr_pkg::MODE_INDEX:        u = 5'b01011;      // [RULE14]
      operand_addr_pkg::MODE_SCALED_INDEX: u = 5'b01111;      // [RULE15]
      operand_addr_pkg::MODE_BASED_INDEX:  u = 5'b11001;      // [RULE16]
      operand_addr_pkg::MODE_BASED_SCALED: u = 5'b11101;      // [RULE17]
      operand_addr_pkg::MODE_BASED_INDEX_D: u = 5'b11011;     // [RULE18]
      operand_addr_pkg::MODE_BASED_SCALED_D: u = 5'b11111;    // [RULE19]
      default:                             u = '0;            // [RULE1]
    endcase
    return u;
  endfunction

  function automatic logic [31:0] reg_read
  (
    input logic [REG_CNT*32-1:0] regs,
    input logic [2:0]            sel
  );
    return regs[sel*32 +: 32];
  endfunction

  // ==========================================================
  // decode of the request
  operand_addr_pkg::mode_use_s use_c;
  logic [31:0] base_val;
  logic [31:0] index_val;
  logic [31:0] scaled_index;
  logic [31:0] disp_val;
  logic [31:0] reg_val;
  logic [31:0] reg_operand;
  logic        addr32_c;
  logic        op32_c;
  logic        bad_index;
  logic        needs_extra;
  logic        take;

  assign use_c = mode_use(req.mode);
  assign addr32_c = default_size32 ^ addr_size_override;         // [RULE20]
  assign op32_c = default_size32 ^ op_size_override;             // [RULE20]
  assign base_val = use_c.use_base ? reg_read(reg_file, req.base_sel) : 32'h0; // [RULE6]
  assign index_val = use_c.use_index ? reg_read(reg_file, req.index_sel) : 32'h0;
  // shift, not multiply: scale is always a power of two
  assign scaled_index = use_c.use_scale ? (index_val << req.scale_shift) : index_val; // [RULE8]
  assign bad_index = use_c.use_index && (req.index_sel == operand_addr_pkg::STACK_POINTER_SEL); // [RULE7]
  assign needs_extra = use_c.use_base && use_c.use_index;        // [RULE9]
  assign reg_val = reg_read(reg_file, req.reg_sel);

  disp_extend u_disp
  (
    .size  (operand_addr_pkg::disp_size_e'(
              use_c.use_disp ? req.disp_size : operand_addr_pkg::DISP_NONE)),
    .raw   (req.disp),
    .value (disp_val)
  );

  reg_operand_select u_reg
  (
    .reg_value (reg_val),
    .width     (req.reg_width),
    .high_byte (req.reg_high_byte),
    .value     (reg_operand)
  );

  // ==========================================================
  // state machine: extra clock for base plus index
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_EXTRA = 2'b10
  } agen_state_e;

  agen_state_e state;
  agen_state_e next_state;
  logic [31:0] partial;
  logic [31:0] held_disp;
  logic [31:0] held_seg;
  logic        held_addr32;
  logic        held_op32;
  logic [31:0] next_offset;

  assign take = req_valid && req_ready;

  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE:
        if (take && needs_extra && !bad_index)
          next_state = ST_EXTRA;                                  // [RULE9]
      ST_EXTRA:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // ready drops while the extra clock is spent
  always_ff @(posedge clk)
  begin
    if (srst)
      req_ready <= 1'b0;
    else
      req_ready <= (next_state == ST_IDLE);                      // [RULE9]
  end

  // first half of the base plus index sum, carry dropped
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      partial     <= operand_addr_pkg::RESET_WORD;
      held_disp   <= operand_addr_pkg::RESET_WORD;
      held_seg    <= operand_addr_pkg::RESET_WORD;
      held_addr32 <= 1'b0;
      held_op32   <= 1'b0;
    end
    else if (take)
    begin
      partial     <= base_val + scaled_index;                    // [RULE21]
      held_disp   <= disp_val;
      held_seg    <= req.seg_base;
      held_addr32 <= addr32_c;
      held_op32   <= op32_c;
    end
  end

  // ==========================================================
  // result
  // 16-bit addressing wraps the offset at 64K
  function automatic logic [31:0] size_offset
  (
    input logic [31:0] sum,
    input logic        a32
  );
    return a32 ? sum : {16'h0, sum[15:0]};                       // [RULE20]
  endfunction

  assign next_offset = size_offset(base_val + scaled_index + disp_val, addr32_c); // [RULE10]

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      res_valid   <= 1'b0;
      index_fault <= 1'b0;
      res         <= '0;
    end
    else if (state == ST_EXTRA)
    begin
      res_valid      <= 1'b1;
      index_fault    <= 1'b0;
      res.is_memory  <= 1'b1;
      res.offset     <= size_offset(partial + held_disp, held_addr32); // [RULE21]
      res.linear     <= held_seg + size_offset(partial + held_disp, held_addr32); // [RULE4]
      res.operand    <= 32'h0;
      res.addr32     <= held_addr32;
      res.op32       <= held_op32;
    end
    // a refused index must leave the last result untouched
    else if (take && !needs_extra && !bad_index)
    begin
      res_valid      <= 1'b1;
      index_fault    <= 1'b0;
      res.is_memory  <= use_c.is_memory;
      res.offset     <= use_c.is_memory ? next_offset : 32'h0;   // [RULE10]
      res.linear     <= use_c.is_memory ? req.seg_base + next_offset : 32'h0; // [RULE4]
      res.addr32     <= addr32_c;
      res.op32       <= op32_c;
      if (req.mode == operand_addr_pkg::MODE_IMMEDIATE)
        res.operand  <= req.immediate;                           // [RULE3]
      else if (req.mode == operand_addr_pkg::MODE_REGISTER)
        res.operand  <= reg_operand;                             // [RULE2]
      else
        res.operand  <= 32'h0;
    end
    else if (take)
    begin
      res_valid   <= 1'b0;
      index_fault <= bad_index;                                  // [RULE7]
    end
    else
    begin
      res_valid   <= 1'b0;
      index_fault <= 1'b0;
    end
  end

endmodule

// *** tb/reg_bank_model.sv ***
// general register file stand-in for the bench
`timescale 1ns/1ps
module reg_bank_model
(
  input  wire logic [31:0]  salt,
  output logic      [255:0] reg_file
);
  // ====
  // contents
  // every byte differs per register, so a wrong select cannot hide
  always_comb
    for (int n = 0; n < 8; n++)
      reg_file[n*32+:32] = {4{8'(n)}} ^ salt ^ (32'h0101_0301 << n);
endmodule

// *** tb/operand_address_generator_properties.sv ***
// port checker for the operand address generator
`timescale 1ns/1ps
module operand_address_generator_properties
#(
  parameter int REG_CNT = 8
)
(
  input wire logic                        clk,
  input wire logic                        srst,
  input wire logic                        req_valid,
  input wire operand_addr_pkg::addr_req_s req,
  input wire logic                        default_size32,
  input wire logic                        op_size_override,
  input wire logic                        addr_size_override,
  input wire logic [REG_CNT*32-1:0]       reg_file,
  input wire logic                        req_ready,
  input wire logic                        res_valid,
  input wire operand_addr_pkg::addr_res_s res,
  input wire logic                        index_fault
);
  // ====
  // request capture
  logic                        take;
  logic                        pair;
  logic                        sp;
  operand_addr_pkg::addr_req_s held;
  logic                        h_a32;
  logic                        h_o32;
  assign take = req_valid && req_ready;
  assign pair = req.mode >= operand_addr_pkg::MODE_BASED_INDEX;
  // index-using modes are codes 5 and up
  assign sp = req.mode >= operand_addr_pkg::MODE_INDEX
           && req.index_sel == operand_addr_pkg::STACK_POINTER_SEL;
  always_ff @(posedge clk)
    if (take)
    begin
      held <= req;
      h_a32 <= default_size32 ^ addr_size_override;
      h_o32 <= default_size32 ^ op_size_override;
    end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_pair_wait;
    !res_valid && !req_ready ##1 res_valid && req_ready;
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0) srst |=> !req_ready && !res_valid)
    else $error("outputs active after reset");
  a_fast_answer: assert property (take && !pair && !sp |=> res_valid && !index_fault)
    else $error("single step result missing");
  a_pair_answer: assert property (take && pair && !sp |=> s_pair_wait)
    else $error("base plus index timing wrong");
  a_sp_refused: assert property (take && sp |=> !res_valid ##[0:1] index_fault)
    else $error("stack pointer index not refused");
  a_result_holds: assert property (!res_valid && !$past(srst) |-> $stable(res))
    else $error("result moved without valid");
  a_linear_sum: assert property (res_valid && res.is_memory |-> res.linear == held.seg_base + res.offset)
    else $error("linear address not base plus offset");
  a_size_select: assert property (res_valid |-> res.addr32 == h_a32 && res.op32 == h_o32)
    else $error("size selection wrong");
  a_mode_kind: assert property (res_valid |-> res.is_memory == (held.mode >= operand_addr_pkg::MODE_DIRECT))
    else $error("memory flag wrong for mode");
endmodule
bind operand_address_generator operand_address_generator_properties #(.REG_CNT(REG_CNT)) props
(
  .clk(clk), .srst(srst), .req_valid(req_valid), .req(req), .default_size32(default_size32),
  .op_size_override(op_size_override), .addr_size_override(addr_size_override),
  .reg_file(reg_file), .req_ready(req_ready), .res_valid(res_valid), .res(res),
  .index_fault(index_fault)
);

// *** tb/operand_address_generator_test.sv ***
// self-checking bench for the operand address generator
`timescale 1ns/1ps
module operand_address_generator_test;
  typedef operand_addr_pkg::addr_req_s rq_s;
  logic                        clk = 1'b0;
  logic                        srst = 1'b1;
  logic                        req_valid = 1'b0;
  rq_s                         req = '0;
  logic                        d32 = 1'b1;
  logic                        oo = 1'b0;
  logic                        ao = 1'b0;
  logic [31:0]                 salt = 32'h0;
  logic [255:0]                regs;
  logic                        ready;
  logic                        rv;
  logic                        fault;
  operand_addr_pkg::addr_res_s res;
  int                          n_errors = 0;
  int                          n_compared = 0;
  always #25 clk = ~clk;
  reg_bank_model bank (.salt(salt), .reg_file(regs));
  operand_address_generator dut
  (
    .clk(clk), .srst(srst), .req_valid(req_valid), .req(req), .default_size32(d32),
    .op_size_override(oo), .addr_size_override(ao), .reg_file(regs), .req_ready(ready),
    .res_valid(rv), .res(res), .index_fault(fault)
  );
  // ====
  // checking and closing
  task automatic report_and_stop();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // hold the request until ready, then wait a bounded time for the answer
  task automatic issue(input rq_s r, output int lat);
    int n;
    n = 0;
    @(posedge clk);
    req <= r;
    req_valid <= 1'b1;
    @(negedge clk);
    while (ready !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        n_errors++;
        report_and_stop();
      end
      @(negedge clk);
    end
    @(posedge clk);
    req_valid <= 1'b0;
    lat = 0;
    do
    begin
      @(negedge clk);
      lat++;
      if (lat > 4)
      begin
        n_errors++;
        report_and_stop();
      end
    end while (rv !== 1'b1 && fault !== 1'b1);
  endtask
  // ====
  // expected values
  function automatic logic [31:0] exp_off(rq_s r, logic a32);
    logic [31:0] b;
    logic [31:0] x;
    logic [31:0] d;
    logic [31:0] s;
    b = regs[r.base_sel*32+:32];
    x = regs[r.index_sel*32+:32];
    d = r.disp_size == 2'h1 ? {{24{r.disp[7]}}, r.disp[7:0]} :
        r.disp_size == 2'h2 ? {{16{r.disp[15]}}, r.disp[15:0]} :
        r.disp_size == 2'h3 ? r.disp : 32'h0;
    case (r.mode)
      4'h2: s = d;
      4'h3: s = b;
      4'h4: s = b + d;
      4'h5: s = x + d;
      4'h6: s = (x << r.scale_shift) + d;
      4'h7: s = b + x;
      4'h8: s = b + (x << r.scale_shift);
      4'h9: s = b + x + d;
      default: s = b + (x << r.scale_shift) + d;
    endcase
    return a32 ? s : {16'h0, s[15:0]};
  endfunction
  function automatic logic [31:0] exp_opd(rq_s r);
    logic [31:0] v;
    v = regs[r.reg_sel*32+:32];
    if (r.mode == operand_addr_pkg::MODE_IMMEDIATE)
      return r.immediate;
    if (r.reg_width == operand_addr_pkg::WIDTH_32)
      return v;
    if (r.reg_width == operand_addr_pkg::WIDTH_16)
      return {16'h0, v[15:0]};
    return {24'h0, r.reg_high_byte ? v[15:8] : v[7:0]};
  endfunction
  task automatic run(input rq_s r);
    int          lat;
    logic        a32;
    logic [31:0] off;
    issue(r, lat);
    a32 = d32 ^ ao;
    off = exp_off(r, a32);
    if (r.mode >= operand_addr_pkg::MODE_DIRECT)
    begin
      check(res.offset, off);
      check(res.linear, r.seg_base + off);
    end
    else
      check(res.operand, exp_opd(r));
    check(32'(lat), r.mode >= operand_addr_pkg::MODE_BASED_INDEX ? 32'h2 : 32'h1);
    check(32'({res.addr32, res.op32}), 32'({a32, d32 ^ oo}));
  endtask
  // ====
  // scenarios
  task automatic t_modes();
    rq_s r;
    r = '0;
    r.base_sel = 3'h5;
    r.index_sel = 3'h6;
    r.disp = 32'hffff_8081;
    r.seg_base = 32'hffff_ff00;
    for (int k = 0; k < 144; k++)
    begin
      r.mode = operand_addr_pkg::addr_mode_e'(2 + k % 9);
      r.scale_shift = 2'(k / 9);
      r.disp_size = operand_addr_pkg::disp_size_e'(k / 36);
      run(r);
    end
  endtask
  task automatic t_regs();
    rq_s r;
    r = '0;
    r.reg_sel = 3'h7;
    for (int k = 0; k < 6; k++)
    begin
      r.reg_width = operand_addr_pkg::op_width_e'(k / 2);
      r.reg_high_byte = k[0];
      run(r);
    end
    r.mode = operand_addr_pkg::MODE_IMMEDIATE;
    r.immediate = 32'h5a3c_0f96;
    run(r);
  endtask
  task automatic t_size();
    rq_s r;
    r = '0;
    r.mode = operand_addr_pkg::MODE_BASED_SCALED_D;
    r.base_sel = 3'h1;
    r.index_sel = 3'h2;
    r.scale_shift = 2'h1;
    r.disp_size = operand_addr_pkg::DISP_16;
    r.disp = 32'h0000_9abc;
    r.seg_base = 32'h0040_0000;
    for (int k = 0; k < 8; k++)
    begin
      @(posedge clk);
      {d32, ao, oo} <= 3'(k);
      run(r);
    end
    @(posedge clk);
    {d32, ao, oo} <= 3'h4;
  endtask
  task automatic t_index_sp();
    rq_s                         r;
    int                          lat;
    operand_addr_pkg::addr_res_s prev;
    r = '0;
    r.mode = operand_addr_pkg::MODE_BASED;
    r.base_sel = 3'h4;
    r.disp_size = operand_addr_pkg::DISP_32;
    r.disp = 32'h0000_1000;
    run(r);
    prev = res;
    r.index_sel = 3'h4;
    // new segment and scale, so any write to the result would show
    r.scale_shift = 2'h1;
    r.seg_base = 32'h0000_4000;
    for (int m = 5; m <= 10; m++)
    begin
      r.mode = operand_addr_pkg::addr_mode_e'(m);
      issue(r, lat);
      check(32'({fault, rv}), 32'h2);
      check(res.linear, prev.linear);
    end
  endtask
  task automatic t_reset();
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(negedge clk);
    check(32'({ready, rv, fault}), 32'h0);
    check(res.offset, 32'h0);
    @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(negedge clk);
    check(32'(ready), 32'h1);
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(negedge clk);
    check(32'(ready), 32'h1);
    check(res.linear, 32'h0);
    t_modes();
    @(posedge clk);
    salt <= 32'h8765_4321;
    t_regs();
    t_size();
    t_index_sp();
    t_reset();
    report_and_stop();
  end
endmodule
